//--- inc/unpriv_sub_pkg.sv
// Purpose: Constants and types for the unprivileged store and
//          subtract-immediate decode and execute block.
// Assumes: One 100 MHz clock, asynchronous active-high reset.
// Notes:   Register offsets are byte addresses on the plain port.
// What this block does
// - Halfword store writes source bits 15:0 to base plus unsigned offset.
// - Both unprivileged stores are marked as unprivileged accesses, always.
// - Word store writes all 32 source bits as a 4-byte access.
// - Store offset is an unsigned 8-bit value, 0 to 255, always added.
// - An omitted offset is a zero field, so the base is used unchanged.
// - Stores use pre-offset addressing, no write-back, no register offset.
// - A store with base field all ones is undefined.
// - A store with source index 13 or 15 is unpredictable.
// - Subtract writes first operand minus decoded immediate to destination.
// - Short three-field form zero-extends imm, flags outside cond block.
// - Short 8-bit form uses one field as source and destination.
// - Wide subtract sets flags on S, immediate by modified expansion.
// - Wide subtract with destination all ones and S decodes as compare.
// - Wide subtract with first operand stack pointer redirects to SP form.
// - Wide subtract, destination 13 or 15 or operand 15, is unpredictable.
// - Result is operand plus inverted imm plus one; flags from adder.
package unpriv_sub_pkg;

    localparam logic [7:0]  off_status  = 8'h00;
    localparam logic [7:0]  off_mask    = 8'h04;
    localparam logic [7:0]  off_control = 8'h08;
    localparam logic [7:0]  off_retired = 8'h0c;
    localparam logic [7:0]  off_flags   = 8'h10;

    localparam logic [2:0]  mask_reset    = 3'h0;
    localparam logic        enable_reset  = 1'h1;
    localparam logic [3:0]  flags_reset   = 4'h0;

    localparam int          ev_undefined   = 0;
    localparam int          ev_unpredict   = 1;
    localparam int          ev_redirect    = 2;
    localparam int          num_events     = 3;

    localparam int          flag_n = 3;
    localparam int          flag_z = 2;
    localparam int          flag_c = 1;
    localparam int          flag_v = 0;

    localparam logic [11:0] op_store_half = 12'hf82;
    localparam logic [11:0] op_store_word = 12'hf84;
    localparam logic [3:0]  op_store_tail = 4'he;
    localparam logic [6:0]  op_sub_three  = 7'h0f;
    localparam logic [4:0]  op_sub_byte   = 5'h07;
    localparam logic [4:0]  op_sub_wide_a = 5'h1e;
    localparam logic [4:0]  op_sub_wide_b = 5'h0d;

    localparam logic [3:0]  idx_sp  = 4'hd;
    localparam logic [3:0]  idx_pc  = 4'hf;

    typedef enum logic [1:0] {
        size_half = 2'b01,
        size_word = 2'b10
    } access_size_t;

    typedef enum logic [1:0] {
        redirect_none       = 2'b00,
        redirect_compare_op = 2'b01,
        redirect_sp_minus   = 2'b10
    } redirect_kind_t;

    typedef struct packed {
        logic [31:0]  addr;
        logic [31:0]  data;
        access_size_t size;
        logic         unpriv;
    } mem_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

endpackage : unpriv_sub_pkg

//--- verilog/unpriv_store_and_sub_imm_decode.sv
// Purpose: Decode and execute of the unprivileged stores and of
//          subtract-immediate in its short and wide forms.
// Assumes: Register file answers read indexes in the same cycle.
// Notes:   Undefined and unpredictable encodings are flagged and
//          suppressed; they never touch memory, registers or flags.
`timescale 1ns/1ns
module unpriv_store_and_sub_imm_decode (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          instr_valid,
    input  wire logic [31:0]                   instr,
    input  wire logic                          instr_wide,
    input  wire logic                          cond_pass,
    input  wire logic                          in_cond_block,
    output logic                               instr_ready,
    output logic [3:0]                         rd_a_idx,
    output logic [3:0]                         rd_b_idx,
    input  wire logic [31:0]                   rd_a_data,
    input  wire logic [31:0]                   rd_b_data,
    output unpriv_sub_pkg::mem_req_t           mem_req,
    output logic                               mem_valid,
    input  wire logic                          mem_ready,
    output logic                               reg_wr,
    output logic [3:0]                         reg_wr_idx,
    output logic [31:0]                        reg_wr_data,
    output logic                               flags_wr,
    output logic [3:0]                         status_flags_reg,
    output logic                               undefined_instr,
    output logic                               unpredictable_instr,
    output logic                               redirect_valid,
    output unpriv_sub_pkg::redirect_kind_t     redirect_kind,
    input  wire unpriv_sub_pkg::bus_req_t      bus,
    output logic [31:0]                        bus_rdata,
    output logic                               irq
);
    import unpriv_sub_pkg::*;

    logic [15:0]          hw1;
    logic [15:0]          hw2;
    logic                 is_store_half;
    logic                 is_store_word;
    logic                 is_store;
    logic                 is_sub_three;
    logic                 is_sub_byte;
    logic                 is_sub_wide;
    logic                 is_sub;
    logic [3:0]           base_reg_field;
    logic [3:0]           source_reg_field;
    logic [7:0]           byte_imm_field;
    logic [2:0]           small_imm_field;
    logic [3:0]           sub_dst;
    logic [31:0]          sub_imm;
    logic                 sub_setflags;
    logic                 dec_undefined;
    logic                 dec_unpredict;
    redirect_kind_t       dec_redirect;
    logic                 accept;
    logic                 execute;
    logic [32:0]          sum;
    logic [31:0]          store_addr;
    logic                 enable;
    logic [num_events-1:0] status;
    logic [num_events-1:0] mask;
    logic [31:0]          retired;
    logic [num_events-1:0] events;

    // Rotates the 8-bit seed of a modified immediate to its place.
    function automatic logic [31:0] modified_imm_expand(
        input logic [11:0] imm12
    );
        logic [31:0] seed;
        logic [31:0] value;
        logic [4:0]  amount;
        seed   = {24'h000000, 1'b1, imm12[6:0]};
        amount = imm12[11:7];
        value  = (seed >> amount) | (seed << (6'd32 - {1'b0, amount}));
        if (imm12[11:10] == 2'b00)
        begin
            case (imm12[9:8])
                2'b00:   value = {24'h000000, imm12[7:0]};
                2'b01:   value = {8'h00, imm12[7:0], 8'h00, imm12[7:0]};
                2'b10:   value = {imm12[7:0], 8'h00, imm12[7:0], 8'h00};
                default: value = {4{imm12[7:0]}};
            endcase
        end
        return value;
    endfunction : modified_imm_expand

    assign hw1 = instr[31:16];
    assign hw2 = instr[15:0];

    always_comb
    begin
        is_store_half = instr_wide && hw1[15:4] == op_store_half
                        && hw2[11:8] == op_store_tail;
        is_store_word = instr_wide && hw1[15:4] == op_store_word
                        && hw2[11:8] == op_store_tail;
        is_store      = is_store_half || is_store_word;
        is_sub_three  = !instr_wide && instr[15:9] == op_sub_three;
        is_sub_byte   = !instr_wide && instr[15:11] == op_sub_byte;
        is_sub_wide   = instr_wide && hw1[15:11] == op_sub_wide_a
                        && hw1[9:5] == op_sub_wide_b && !hw2[15];
        is_sub        = is_sub_three || is_sub_byte || is_sub_wide;
    end

    always_comb
    begin
        base_reg_field   = hw1[3:0];
        source_reg_field = hw2[15:12];
        byte_imm_field   = hw2[7:0];
        small_imm_field  = instr[8:6];
        sub_dst          = 4'h0;
        sub_imm          = 32'h00000000;
        sub_setflags     = 1'b0;
        rd_b_idx         = source_reg_field;
        rd_a_idx         = base_reg_field;
        if (is_sub_three)
        begin
            rd_a_idx     = {1'b0, instr[5:3]};
            sub_dst      = {1'b0, instr[2:0]};
            sub_imm      = {29'h0, small_imm_field};
            sub_setflags = !in_cond_block;
        end
        else if (is_sub_byte)
        begin
            rd_a_idx     = {1'b0, instr[10:8]};
            sub_dst      = {1'b0, instr[10:8]};
            sub_imm      = {24'h000000, instr[7:0]};
            sub_setflags = !in_cond_block;
        end
        else if (is_sub_wide)
        begin
            sub_dst      = hw2[11:8];
            sub_imm      = modified_imm_expand(
                               {hw1[10], hw2[14:12], hw2[7:0]});
            sub_setflags = hw1[4];
        end
    end

    always_comb
    begin
        dec_undefined = 1'b0;
        dec_unpredict = 1'b0;
        dec_redirect  = redirect_none;
        if (is_store)
        begin
            if (base_reg_field == idx_pc)
                dec_undefined = 1'b1;
            else if (source_reg_field == idx_sp
                     || source_reg_field == idx_pc)
                dec_unpredict = 1'b1;
        end
        else if (is_sub_wide)
        begin
            if (sub_dst == idx_pc && sub_setflags)
                dec_redirect = redirect_compare_op;
            else if (base_reg_field == idx_sp)
                dec_redirect = redirect_sp_minus;
            else if (sub_dst == idx_sp || sub_dst == idx_pc
                     || base_reg_field == idx_pc)
                dec_unpredict = 1'b1;
        end
    end

    // Stalling on a held store keeps one request in flight, so the
    // memory port never needs a queue.
    assign instr_ready = enable && !(mem_valid && !mem_ready);
    assign accept      = instr_valid && instr_ready;
    assign execute     = accept && cond_pass && !dec_undefined
                         && !dec_unpredict
                         && dec_redirect == redirect_none;

    assign sum        = {1'b0, rd_a_data} + {1'b0, ~sub_imm} + 33'h1;
    assign store_addr = rd_a_data + {24'h000000, byte_imm_field};

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mem_valid <= 1'b0;
            mem_req   <= '0;
        end
        else if (execute && is_store)
        begin
            mem_valid      <= 1'b1;
            mem_req.addr   <= store_addr;
            mem_req.unpriv <= 1'b1;
            if (is_store_half)
            begin
                mem_req.data <= {16'h0000, rd_b_data[15:0]};
                mem_req.size <= size_half;
            end
            else
            begin
                mem_req.data <= rd_b_data;
                mem_req.size <= size_word;
            end
        end
        else if (mem_ready)
        begin
            mem_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            reg_wr      <= 1'b0;
            reg_wr_idx  <= 4'h0;
            reg_wr_data <= 32'h00000000;
        end
        else
        begin
            reg_wr <= execute && is_sub;
            if (execute && is_sub)
            begin
                reg_wr_idx  <= sub_dst;
                reg_wr_data <= sum[31:0];
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            flags_wr         <= 1'b0;
            status_flags_reg <= flags_reset;
        end
        else
        begin
            flags_wr <= execute && is_sub && sub_setflags;
            if (execute && is_sub && sub_setflags)
            begin
                status_flags_reg[flag_n] <= sum[31];
                status_flags_reg[flag_z] <= sum[31:0] == 32'h0;
                status_flags_reg[flag_c] <= sum[32];
                status_flags_reg[flag_v] <= (rd_a_data[31] != sub_imm[31])
                    && (sum[31] != rd_a_data[31]);
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            undefined_instr     <= 1'b0;
            unpredictable_instr <= 1'b0;
            redirect_valid      <= 1'b0;
            redirect_kind       <= redirect_none;
        end
        else
        begin
            undefined_instr     <= accept && dec_undefined;
            unpredictable_instr <= accept && dec_unpredict;
            redirect_valid      <= accept && dec_redirect != redirect_none;
            redirect_kind       <= accept ? dec_redirect : redirect_none;
        end
    end

    assign events = {redirect_valid, unpredictable_instr, undefined_instr};

    // A new event wins over a write-one clear in the same cycle.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            status <= '0;
        else if (bus.wr && bus.addr[7:0] == off_status)
            status <= (status & ~bus.wdata[num_events-1:0]) | events;
        else
            status <= status | events;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mask   <= mask_reset;
            enable <= enable_reset;
        end
        else if (bus.wr && bus.addr[7:0] == off_mask)
            mask <= bus.wdata[num_events-1:0];
        else if (bus.wr && bus.addr[7:0] == off_control)
            enable <= bus.wdata[0];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            retired <= 32'h00000000;
        else if (bus.wr && bus.addr[7:0] == off_retired)
            retired <= 32'h00000000;
        else if (execute)
            retired <= retired + 32'h1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            bus_rdata <= 32'h00000000;
        else if (bus.rd)
        begin
            case (bus.addr[7:0])
                off_status:  bus_rdata <= {29'h0, status};
                off_mask:    bus_rdata <= {29'h0, mask};
                off_control: bus_rdata <= {31'h0, enable};
                off_retired: bus_rdata <= retired;
                off_flags:   bus_rdata <= {28'h0, status_flags_reg};
                default:     bus_rdata <= 32'h00000000;
            endcase
        end
        else
            bus_rdata <= 32'h00000000;
    end

    assign irq = |(status & mask);

    a_half_store_addr: assert property (@(posedge clk)
        disable iff (reset)
        execute && is_store_half |=> mem_valid && mem_req.size == size_half
        && mem_req.addr == $past(rd_a_data) + {24'h0, $past(instr[7:0])}
        && mem_req.data == {16'h0000, $past(rd_b_data[15:0])})
        else $error("Halfword store address or data wrong.");

    a_store_unpriv: assert property (@(posedge clk) disable iff (reset)
        mem_valid |-> mem_req.unpriv)
        else $error("Store not marked unprivileged.");

    a_word_store_data: assert property (@(posedge clk)
        disable iff (reset)
        execute && is_store_word |=> mem_valid && mem_req.size == size_word
        && mem_req.data == $past(rd_b_data))
        else $error("Word store data or size wrong.");

    a_undef_base: assert property (@(posedge clk) disable iff (reset)
        accept && is_store && instr[19:16] == 4'hf
        |=> undefined_instr && !mem_valid && !reg_wr)
        else $error("Store with base all ones not undefined.");

    a_unpred_source: assert property (@(posedge clk) disable iff (reset)
        accept && is_store && instr[19:16] != 4'hf
        && (instr[15:12] == 4'hd || instr[15:12] == 4'hf)
        |=> unpredictable_instr && !mem_valid)
        else $error("Store with source 13 or 15 not flagged.");

    a_sub_result: assert property (@(posedge clk) disable iff (reset)
        execute && is_sub |=> reg_wr
        && reg_wr_data == $past(rd_a_data) - $past(sub_imm))
        else $error("Subtract result wrong.");

    a_flags_cond_block: assert property (@(posedge clk)
        disable iff (reset)
        accept && (is_sub_three || is_sub_byte) && in_cond_block
        |=> !flags_wr && $stable(status_flags_reg))
        else $error("Flags updated inside conditional block.");

    a_compare_redirect: assert property (@(posedge clk)
        disable iff (reset)
        accept && is_sub_wide && hw1[4] && hw2[11:8] == 4'hf
        |=> redirect_valid && redirect_kind == redirect_compare_op && !reg_wr)
        else $error("Compare redirect missed.");

    a_sp_redirect: assert property (@(posedge clk) disable iff (reset)
        accept && is_sub_wide && hw1[3:0] == 4'hd
        && !(hw1[4] && hw2[11:8] == 4'hf)
        |=> redirect_kind == redirect_sp_minus && !reg_wr)
        else $error("Stack pointer redirect missed.");

    a_zero_flag: assert property (@(posedge clk) disable iff (reset)
        flags_wr |-> status_flags_reg[flag_z] == (reg_wr_data == 32'h0)
        && status_flags_reg[flag_n] == reg_wr_data[31])
        else $error("Zero or negative flag does not match result.");

    a_cond_fail_idle: assert property (@(posedge clk)
        disable iff (reset)
        accept && !cond_pass |=> !reg_wr && !flags_wr && !mem_valid)
        else $error("Instruction executed with condition failed.");

endmodule : unpriv_store_and_sub_imm_decode

//--- dv/mem_port_model.sv
// Purpose: Memory port partner that takes store requests.
// Assumes: Ready may be held off for a chosen number of cycles.
// Notes:   Keeps the last request taken and a count of them.
`timescale 1ns/1ns
module mem_port_model (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                mem_valid,
    input  wire unpriv_sub_pkg::mem_req_t mem_req,
    input  wire logic [3:0]          stall,
    output logic                     mem_ready,
    output unpriv_sub_pkg::mem_req_t seen_req,
    output logic [7:0]               seen_count
);
    import unpriv_sub_pkg::*;
    logic [3:0] waited;

    // Holding ready off proves that a pending store keeps its request.
    assign mem_ready = mem_valid && (waited >= stall);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            waited     <= 4'h0;
            seen_count <= 8'h00;
            seen_req   <= '0;
        end
        else if (mem_valid && mem_ready)
        begin
            waited     <= 4'h0;
            seen_count <= seen_count + 8'h01;
            seen_req   <= mem_req;
        end
        else if (mem_valid)
            waited <= waited + 4'h1;
    end
endmodule : mem_port_model

//--- dv/unpriv_store_and_sub_imm_decode_tb_top.sv
// Purpose: Self-checking bench for the store and subtract decoder.
// Assumes: The register file is a bench array read in the same cycle.
// Notes:   Each scenario task drives the block and judges the answer.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module unpriv_store_and_sub_imm_decode_tb_top;
    import unpriv_sub_pkg::*;
    logic           clk, reset, instr_valid, instr_wide, cond_pass;
    logic           in_cond_block, instr_ready, mem_valid, mem_ready;
    logic           reg_wr, flags_wr, undefined_instr, irq;
    logic           unpredictable_instr, redirect_valid;
    logic [31:0]    instr, reg_wr_data, bus_rdata, rd_a_data, rd_b_data;
    logic [31:0]    rf [16];
    logic [31:0]    c_data;
    logic [3:0]     rd_a_idx, rd_b_idx, reg_wr_idx, status_flags_reg;
    logic [3:0]     stall, c_idx, c_fl, exp_fl;
    logic [5:0]     c_ev;
    logic [7:0]     seen_count;
    mem_req_t       mem_req, seen_req;
    redirect_kind_t redirect_kind, c_kind;
    bus_req_t       bus;
    int             errors, n_checks;

    assign rd_a_data = rf[rd_a_idx];
    assign rd_b_data = rf[rd_b_idx];

    unpriv_store_and_sub_imm_decode dut (.clk, .reset, .instr_valid,
        .instr, .instr_wide, .cond_pass, .in_cond_block, .instr_ready,
        .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data, .mem_req,
        .mem_valid, .mem_ready, .reg_wr, .reg_wr_idx, .reg_wr_data,
        .flags_wr, .status_flags_reg, .undefined_instr,
        .unpredictable_instr, .redirect_valid, .redirect_kind, .bus,
        .bus_rdata, .irq);

    mem_port_model mem (.clk, .reset, .mem_valid, .mem_req, .stall,
        .mem_ready, .seen_req, .seen_count);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic timeout();
        errors++;
        $display("[ERR] wait for the block timed out");
        give_verdict();
    endtask : timeout

    function automatic logic [31:0] st_enc(input logic wd,
        input logic [3:0] rn, rt, input logic [7:0] off);
        return {wd ? op_store_word : op_store_half, rn, rt,
                op_store_tail, off};
    endfunction : st_enc

    function automatic logic [31:0] wide(input logic s,
        input logic [3:0] rn, rd, input logic [11:0] v);
        return {op_sub_wide_a, v[11], op_sub_wide_b, s, rn, 1'b0,
                v[10:8], rd, v[7:0]};
    endfunction : wide

    function automatic logic [31:0] expand(input logic [11:0] v);
        logic [31:0] u;
        u = {24'h0, 1'b1, v[6:0]};
        case (v[11:8])
            4'h0: return {24'h0, v[7:0]};
            4'h1: return {8'h0, v[7:0], 8'h0, v[7:0]};
            4'h2: return {v[7:0], 8'h0, v[7:0], 8'h0};
            4'h3: return {4{v[7:0]}};
            default: return (u >> v[11:7]) | (u << (6'd32 - v[11:7]));
        endcase
    endfunction : expand

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: {24'h0, a}, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : bus_wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk);
        bus <= '{addr: {24'h0, a}, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 `CHK("register read", ex, bus_rdata)
    endtask : rd_chk

    task automatic issue(input logic [31:0] i, input logic w, c, b);
        int k;
        @(posedge clk);
        instr         <= i;
        instr_wide    <= w;
        cond_pass     <= c;
        in_cond_block <= b;
        instr_valid   <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            #1;
            if (instr_ready === 1'b1)
                break;
            @(posedge clk);
        end
        if (k == 20)
            timeout();
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        c_ev   = {mem_valid, reg_wr, flags_wr, undefined_instr,
                  unpredictable_instr, redirect_valid};
        c_idx  = reg_wr_idx;
        c_data = reg_wr_data;
        c_fl   = status_flags_reg;
        c_kind = redirect_kind;
    endtask : issue

    task automatic t_store(input logic wd, input logic [3:0] rn, rt,
                           input logic [7:0] off, input logic [3:0] st);
        logic [7:0]  n0;
        logic [31:0] ea, ed;
        int          k;
        n0    = seen_count;
        stall = st;
        ea    = rf[rn] + {24'h0, off};
        ed    = wd ? rf[rt] : {16'h0, rf[rt][15:0]};
        issue(st_enc(wd, rn, rt, off), 1'b1, 1'b1, 1'b0);
        if (st != 4'h0)
            `CHK("ready while held", 1'b0, instr_ready)
        for (k = 0; k < 20 && seen_count == n0; k++)
        begin
            @(posedge clk);
            #1;
        end
        if (k == 20)
            timeout();
        `CHK("store addr", ea, seen_req.addr)
        `CHK("store data", ed, seen_req.data)
        `CHK("store size", wd ? size_word : size_half, seen_req.size)
        `CHK("store unpriv", 1'b1, seen_req.unpriv)
        $display("store test done");
    endtask : t_store

    task automatic t_ev(input logic [31:0] i, input logic c,
                        input logic [5:0] ex, input redirect_kind_t rk);
        issue(i, 1'b1, c, 1'b0);
        `CHK("event pulses", ex, c_ev)
        `CHK("redirect kind", rk, c_kind)
        $display("event test done");
    endtask : t_ev

    task automatic t_sub(input logic [31:0] i, input logic w, b,
                         input logic [3:0] rd, input logic [31:0] a, m,
                         input logic sf);
        logic [32:0] r;
        r = {1'b0, a} + {1'b0, ~m} + 33'h1;
        if (sf)
            exp_fl = {r[31], r[31:0] == 32'h0, r[32],
                      (a[31] != m[31]) && (r[31] != a[31])};
        issue(i, w, 1'b1, b);
        `CHK("sub pulses", {2'b01, sf, 3'b000}, c_ev)
        `CHK("sub dest", rd, c_idx)
        `CHK("sub result", r[31:0], c_data)
        `CHK("sub flags", exp_fl, c_fl)
        $display("subtract test done");
    endtask : t_sub

    task automatic t_regs();
        rd_chk(off_status, 32'h7);
        `CHK("irq masked", 1'b0, irq)
        bus_wr(off_mask, 32'h2);
        `CHK("irq raised", 1'b1, irq)
        bus_wr(off_status, 32'h2);
        `CHK("irq cleared", 1'b0, irq)
        rd_chk(off_status, 32'h5);
        bus_wr(off_status, 32'h5);
        rd_chk(off_retired, 32'hd);
        bus_wr(off_retired, 32'h0);
        rd_chk(off_retired, 32'h0);
        bus_wr(off_control, 32'h0);
        `CHK("ready when disabled", 1'b0, instr_ready)
        bus_wr(off_control, 32'h1);
        $display("register test done");
    endtask : t_regs

    initial
    begin
        logic [11:0] tab [6];
        tab = '{12'h0ab, 12'h1ab, 12'h2cd, 12'h3ef, 12'h47f, 12'hfff};
        reset         = 1'b1;
        errors        = 0;
        n_checks      = 0;
        bus           = '0;
        instr         = 32'h0;
        instr_valid   = 1'b0;
        instr_wide    = 1'b0;
        cond_pass     = 1'b0;
        in_cond_block = 1'b0;
        stall         = 4'h0;
        exp_fl        = flags_reset;
        for (int i = 0; i < 16; i++)
            rf[i] = 32'h12345679 * (i + 1);
        rf[3] = 32'h00000042;
        rf[4] = 32'h80000000;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd_chk(off_mask, {29'h0, mask_reset});
        rd_chk(off_control, {31'h0, enable_reset});
        rd_chk(off_flags, {28'h0, flags_reset});
        rd_chk(off_status, 32'h0);
        rd_chk(8'h40, 32'h0);
        t_store(1'b0, 4'h1, 4'h2, 8'hff, 4'h0);
        t_store(1'b1, 4'hd, 4'h3, 8'h00, 4'h3);
        t_store(1'b0, 4'h5, 4'he, 8'h80, 4'h2);
        t_ev(st_enc(1'b0, 4'hf, 4'h2, 8'h10), 1'b0, 6'h04,
             redirect_none);
        t_ev(st_enc(1'b1, 4'hf, 4'h2, 8'h10), 1'b1, 6'h04,
             redirect_none);
        t_ev(st_enc(1'b0, 4'h1, 4'hd, 8'h10), 1'b1, 6'h02,
             redirect_none);
        t_ev(st_enc(1'b1, 4'h1, 4'hf, 8'h10), 1'b1, 6'h02,
             redirect_none);
        t_ev(st_enc(1'b1, 4'h1, 4'h2, 8'h10), 1'b0, 6'h00,
             redirect_none);
        t_ev(wide(1'b1, 4'h1, 4'hf, 12'h010), 1'b1, 6'h01,
             redirect_compare_op);
        t_ev(wide(1'b0, 4'hd, 4'h2, 12'h010), 1'b1, 6'h01,
             redirect_sp_minus);
        t_ev(wide(1'b0, 4'h1, 4'hd, 12'h010), 1'b1, 6'h02,
             redirect_none);
        t_ev(wide(1'b0, 4'h1, 4'hf, 12'h010), 1'b1, 6'h02,
             redirect_none);
        t_ev(wide(1'b1, 4'hf, 4'h2, 12'h010), 1'b1, 6'h02,
             redirect_none);
        t_sub({16'h0, op_sub_three, 3'h5, 3'h1, 3'h2}, 1'b0, 1'b0,
              4'h2, rf[1], 32'h5, 1'b1);
        t_sub({16'h0, op_sub_three, 3'h7, 3'h1, 3'h2}, 1'b0, 1'b1,
              4'h2, rf[1], 32'h7, 1'b0);
        t_sub({16'h0, op_sub_byte, 3'h3, 8'h42}, 1'b0, 1'b0,
              4'h3, rf[3], 32'h42, 1'b1);
        t_sub({16'h0, op_sub_byte, 3'h4, 8'h01}, 1'b0, 1'b0,
              4'h4, rf[4], 32'h1, 1'b1);
        for (int j = 0; j < 6; j++)
            t_sub(wide(j[0], 4'h6, 4'h7, tab[j]), 1'b1, 1'b1, 4'h7, rf[6],
                  expand(tab[j]), j[0]);
        t_regs();
        give_verdict();
    end
endmodule : unpriv_store_and_sub_imm_decode_tb_top
